// file: rtl/relay_params.svh
// offsets, field limits, reset values and timing counts of the relay block
`ifndef RELAY_PARAMS_SVH
`define RELAY_PARAMS_SVH
`define ADDR_W 8
`define OFS_STARTS 8'h00
`define OFS_HIST_SEL 8'h04
`define OFS_HIST_A 8'h08
`define OFS_HIST_B 8'h0C
`define OFS_IND_RST 8'h10
`define OFS_FULL_RST 8'h14
`define OFS_BANK 8'h18
`define OFS_SGX 8'h1C
`define OFS_MASK_STG 8'h20
`define OFS_MASK_A 8'h24
`define OFS_MASK_B 8'h28
`define OFS_PW_OPEN 8'h2C
`define OFS_PW_CHG 8'h30
`define OFS_SELF_SUP 8'h34
`define OFS_FORMAT 8'h38
`define OFS_FAULT 8'h3C
`define OFS_STATION 8'h40
`define OFS_RATE 8'h44
`define OFS_VERSION 8'h48
`define OFS_EVT_CMD 8'h4C
`define OFS_EVT_CNT 8'h50
`define OFS_EVT_DATA 8'h54
`define OFS_EVT_LAST 8'h64
`define OFS_STATUS 8'h68
`define OFS_TIME 8'h6C
`define W_ONE 32'h00000001
`define W_TWO 32'h00000002
`define W_SGX_MAX 32'h0000003F
`define W_MASK_STG_MAX 32'h00000FFF
`define W_MASK_OUT_MAX 32'h000000FF
`define W_PW_MAX 32'h000003E7
`define W_ADDR_MAX 32'h000000FE
`define W_TIME_MAX 32'h0000EA5F
`define W_HIST_MAX 32'h00000004
`define TIME_MAX 16'hEA5F
`define ANGLE_INVALID 11'h3E7
`define COUNT_MAX 8'hFF
`define HIST_DEPTH 5
`define BATCH 5
`define BATCH_LAST 3'h4
`define EVT_DEPTH 65
`define EVT_FULL 7'h41
`define EVT_LAST 7'h40
`define MASK_STG_RST 12'hFFF
`define MASK_OUT_RST 8'hFF
`define PW_RST 10'h001
`define ADDR_RST 8'h01
`define VERSION_ID 8'h5A
`define FC_TRIP 8'h04
`define FC_ROM 8'h1E
`define FC_RAM 8'h32
`define FC_EE_B1 8'h33
`define FC_EE_B2 8'h34
`define FC_EE_BOTH 8'h35
`define FC_EE_CKS 8'h36
`define FC_RAM_PAR 8'h37
`define FC_EE_KEY 8'h38
`define FC_LOW_X1 8'hC3
`define FC_LOW_X5 8'h83
`define FC_LOW_X25 8'h43
`define FC_HIGH_X1 8'hCB
`define FC_HIGH_X5 8'h8B
`define FC_HIGH_X25 8'h4B
`define FC_NEUTRAL 8'hFC
`define FC_NO_ADC 8'hFD
`define CLK_NS 4
`define TICK_NS 1000000
`define MS_CYCLES (`TICK_NS / `CLK_NS)
`endif

// file: rtl/relay_pkg.sv
// types shared by the relay parameter and event blocks
`include "relay_params.svh"
package relay_pkg;
  typedef struct packed {
    logic [6:0] voltage;
    logic [7:0] current;
    logic signed [10:0] angle;
    logic [2:0][6:0] duration;
  } rec_t;
  typedef struct packed {
    logic [5:0] channel;
    logic [7:0] code;
  } evt_in_t;
  typedef struct packed {
    logic [15:0] stamp;
    logic [5:0] channel;
    logic [7:0] code;
  } event_t;
  typedef struct packed {
    logic trip_path;
    logic rom;
    logic ram;
    logic ee_b1;
    logic ee_b2;
    logic ee_cks;
    logic ram_param;
    logic ee_key;
    logic [2:0] ref_low;
    logic [2:0] ref_high;
    logic neutral_chan;
    logic no_adc;
  } fault_t;
  typedef enum logic {st_idle, st_pop} batch_state_t;
endpackage

// file: rtl/event_store.sv
// 65-entry event store, oldest first, drops pushes while full
`timescale 1ns/1ps
`include "relay_params.svh"
module event_store
  import relay_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire event_t push_data,
  input wire logic pop,
  output event_t head,
  output logic empty,
  output logic full
);
  event_t mem [`EVT_DEPTH];
  logic [6:0] wp;
  logic [6:0] rp;
  logic [6:0] cnt;
  wire do_push = push & ~full;
  wire do_pop = pop & ~empty;

  assign full = (cnt == `EVT_FULL);
  assign empty = (cnt == 7'h00);
  assign head = mem[rp];

  function automatic logic [6:0] wrap(input logic [6:0] p);
    wrap = (p == `EVT_LAST) ? 7'h00 : p + 7'h01;
  endfunction

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wp] <= push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp <= 7'h00;
      rp <= 7'h00;
      cnt <= 7'h00;
    end else begin
      if (do_push) wp <= wrap(wp);
      if (do_pop) rp <= wrap(rp);
      if (do_push & ~do_pop) cnt <= cnt + 7'h01;
      else if (do_pop & ~do_push) cnt <= cnt - 7'h01;
    end
  end
endmodule

// file: rtl/relay_parameter_event_interface.sv
// relay parameter, history and event interface behind an APB slave
//
// Summary of operation
// - three read-only start counters, one per stage, saturating at 255
// - five newest recordings kept; new recording shifts older ones back
// - recording holds voltage, current, angle, durations; angle 999 if small
// - writing 1 clears indicators and releases latched relay
// - writing 1 clears indicators, relays and recorded values
// - bank select read/write; 0 main bank, 1 second bank
// - stage mask 0..4095 and two output masks 0..255, read/write
// - writing password 1..999 opens remote setting
// - password change or close, 0..999, only while opened
// - writing 1 asserts self-supervision output and fault indicator
// - key fault reports 56; protected write of 2 formats memory
// - memory faults report 30, 50, 51 to 55
// - reference too low reports 195, 131, 67 for gain 1, 5, 25
// - reference too high reports 203, 139, 75 for gain 1, 5, 25
// - codes 4 trip path, 252 neutral channel, 253 missing converter
// - station address read/write, limited to 1..254
// - event register holds at most 65 pending events
// - each event carries time stamp, channel and code
// - read command returns up to 5 events, consumed once
// - re-read command returns last batch again, consuming nothing
// - status 0 normal, 1 auto reset, 2 overflow, 3 both
// - writing 0 to status clears abnormal conditions
// - millisecond time counter read/write, wrapping at 59.999 s
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`include "relay_params.svh"
module relay_parameter_event_interface
  import relay_pkg::*;
#(
  parameter int MS_CYCLES = `MS_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] start_pulse,
  input wire logic rec_valid,
  input wire rec_t rec_in,
  input wire logic rec_angle_low,
  input wire logic evt_valid,
  input wire evt_in_t evt_in,
  input wire logic auto_reset_seen,
  input wire fault_t fault_in,
  output logic ind_clear,
  output logic relay_release,
  output logic setting_bank_select,
  output logic [5:0] option_switch_group,
  output logic self_supervision_out,
  output logic internal_fault_indicator,
  output logic format_req,
  output logic [7:0] station_address,
  output logic link_rate
);
  ////////////////////////////////////////////////////////////////////////////
  logic [2:0][7:0] start_count;
  rec_t hist [`HIST_DEPTH];
  logic [2:0] hist_sel;
  logic [11:0] stage_event_mask;
  logic [7:0] output_event_mask_a;
  logic [7:0] output_event_mask_b;
  logic [9:0] password;
  logic remote_open;
  logic [7:0] internal_fault_code;
  logic st_auto;
  logic st_overflow;
  logic [15:0] time_ms;
  logic [31:0] ms_div;
  event_t batch [`BATCH];
  logic [2:0] batch_cnt;
  batch_state_t state;
  event_t head;
  logic evt_empty;
  logic evt_full;
  logic [31:0] rdata;
  logic mapped;
  logic bad_wr;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; pready is registered, so every access phase takes at least two cycles
  wire acc = psel & penable;
  wire first = acc & ~pready;
  wire take = acc & pready;
  wire ok = take & pwrite & mapped & ~bad_wr;
  wire v_one = (pwdata == `W_ONE);
  wire w_ind = ok & (paddr == `OFS_IND_RST) & v_one;
  wire w_full = ok & (paddr == `OFS_FULL_RST) & v_one;
  wire w_hsel = ok & (paddr == `OFS_HIST_SEL);
  wire w_bank = ok & (paddr == `OFS_BANK);
  wire w_sgx = ok & (paddr == `OFS_SGX);
  wire w_mstg = ok & (paddr == `OFS_MASK_STG);
  wire w_ma = ok & (paddr == `OFS_MASK_A);
  wire w_mb = ok & (paddr == `OFS_MASK_B);
  wire w_open = ok & (paddr == `OFS_PW_OPEN);
  wire w_chg = ok & (paddr == `OFS_PW_CHG);
  wire w_sup = ok & (paddr == `OFS_SELF_SUP) & v_one;
  wire w_fmt = ok & (paddr == `OFS_FORMAT);
  wire w_addr = ok & (paddr == `OFS_STATION);
  wire w_rate = ok & (paddr == `OFS_RATE);
  wire w_evt = ok & (paddr == `OFS_EVT_CMD) & v_one;
  wire w_stat = ok & (paddr == `OFS_STATUS);
  wire w_time = ok & (paddr == `OFS_TIME);
  wire [2:0] dsel = 3'(({24'h0, paddr} - 32'(`OFS_EVT_DATA)) >> 2);

  function automatic logic above(input logic [31:0] v,
                                 input logic [31:0] hi);
    above = (v > hi);
  endfunction

  // protected writes stay refused until the password has been given
  always_comb begin
    mapped = 1'b1;
    bad_wr = 1'b0;
    case (paddr)
      `OFS_STARTS, `OFS_HIST_A, `OFS_HIST_B, `OFS_FAULT, `OFS_VERSION,
      `OFS_EVT_CNT: bad_wr = 1'b1;
      `OFS_IND_RST, `OFS_FULL_RST, `OFS_SELF_SUP: bad_wr = 1'b0;
      `OFS_HIST_SEL: bad_wr = above(pwdata, `W_HIST_MAX);
      `OFS_BANK, `OFS_RATE: bad_wr = above(pwdata, `W_ONE);
      `OFS_SGX: bad_wr = ~remote_open | above(pwdata, `W_SGX_MAX);
      `OFS_MASK_STG: bad_wr = above(pwdata, `W_MASK_STG_MAX);
      `OFS_MASK_A, `OFS_MASK_B: bad_wr = above(pwdata, `W_MASK_OUT_MAX);
      `OFS_PW_OPEN: bad_wr = (pwdata == 32'h0) |
        (pwdata != {22'h0, password});
      `OFS_PW_CHG: bad_wr = ~remote_open | above(pwdata, `W_PW_MAX);
      `OFS_FORMAT: bad_wr = ~remote_open | (pwdata != `W_TWO);
      `OFS_STATION: bad_wr = (pwdata == 32'h0) |
        above(pwdata, `W_ADDR_MAX);
      `OFS_EVT_CMD: bad_wr = (pwdata != `W_ONE) & (pwdata != `W_TWO);
      `OFS_STATUS: bad_wr = (pwdata != 32'h0);
      `OFS_TIME: bad_wr = above(pwdata, `W_TIME_MAX);
      default: begin
        mapped = (paddr >= `OFS_EVT_DATA) && (paddr <= `OFS_EVT_LAST) &&
          (paddr[1:0] == 2'b00);
        bad_wr = 1'b1;
      end
    endcase
  end

  always_comb begin
    rdata = 32'h0;
    case (paddr)
      `OFS_STARTS: rdata = {8'h0, start_count};
      `OFS_HIST_SEL: rdata = {29'h0, hist_sel};
      `OFS_HIST_A: rdata = {{5{hist[hist_sel].angle[10]}},
        hist[hist_sel].angle, hist[hist_sel].current,
        1'b0, hist[hist_sel].voltage};
      `OFS_HIST_B: rdata = {11'h0, hist[hist_sel].duration};
      `OFS_BANK: rdata = {31'h0, setting_bank_select};
      `OFS_SGX: rdata = {26'h0, option_switch_group};
      `OFS_MASK_STG: rdata = {20'h0, stage_event_mask};
      `OFS_MASK_A: rdata = {24'h0, output_event_mask_a};
      `OFS_MASK_B: rdata = {24'h0, output_event_mask_b};
      `OFS_FAULT: rdata = {24'h0, internal_fault_code};
      `OFS_STATION: rdata = {24'h0, station_address};
      `OFS_RATE: rdata = {31'h0, link_rate};
      `OFS_VERSION: rdata = {24'h0, `VERSION_ID}; // arbitrary value
      `OFS_EVT_CNT: rdata = {29'h0, batch_cnt};
      `OFS_STATUS: rdata = {30'h0, st_overflow, st_auto};
      `OFS_TIME: rdata = {16'h0, time_ms};
      default: begin
        if (mapped) begin
          // batch stays readable any number of times
          rdata = (dsel < batch_cnt) ? {2'b00, batch[dsel]} : 32'h0;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      // a pending batch unload stalls the bus
      pready <= first & (state == st_idle);
      pslverr <= first & (state == st_idle) &
        (~mapped | (pwrite & bad_wr));
      if (first & ~pwrite) prdata <= rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // commands and settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_clear <= 1'b0;
      relay_release <= 1'b0;
      format_req <= 1'b0;
      self_supervision_out <= 1'b0;
      internal_fault_indicator <= 1'b0;
      setting_bank_select <= 1'b0;
      option_switch_group <= 6'h00;
      stage_event_mask <= `MASK_STG_RST;
      output_event_mask_a <= `MASK_OUT_RST;
      output_event_mask_b <= `MASK_OUT_RST;
      password <= `PW_RST;
      remote_open <= 1'b0;
      station_address <= `ADDR_RST;
      link_rate <= 1'b0;
      hist_sel <= 3'h0;
      internal_fault_code <= 8'h00;
    end else begin
      ind_clear <= w_ind | w_full;
      relay_release <= w_ind | w_full;
      format_req <= w_fmt;
      if (w_sup) begin
        self_supervision_out <= 1'b1;
        internal_fault_indicator <= 1'b1;
      end
      if (w_bank) setting_bank_select <= pwdata[0];
      if (w_sgx) option_switch_group <= pwdata[5:0];
      if (w_mstg) stage_event_mask <= pwdata[11:0];
      if (w_ma) output_event_mask_a <= pwdata[7:0];
      if (w_mb) output_event_mask_b <= pwdata[7:0];
      if (w_open) remote_open <= 1'b1;
      if (w_chg) begin
        // zero closes remote setting, any other value replaces the key
        if (pwdata[9:0] == 10'h000) remote_open <= 1'b0;
        else password <= pwdata[9:0];
      end
      if (w_addr) station_address <= pwdata[7:0];
      if (w_rate) link_rate <= pwdata[0];
      if (w_hsel) hist_sel <= pwdata[2:0];
      internal_fault_code <= fault_encode(fault_in);
    end
  end

  // first condition found wins when several faults are present
  function automatic logic [7:0] fault_encode(input fault_t f);
    if (f.trip_path) fault_encode = `FC_TRIP;
    else if (f.rom) fault_encode = `FC_ROM;
    else if (f.ram) fault_encode = `FC_RAM;
    else if (f.ee_b1 & f.ee_b2) fault_encode = `FC_EE_BOTH;
    else if (f.ee_b1) fault_encode = `FC_EE_B1;
    else if (f.ee_b2) fault_encode = `FC_EE_B2;
    else if (f.ee_cks) fault_encode = `FC_EE_CKS;
    else if (f.ram_param) fault_encode = `FC_RAM_PAR;
    else if (f.ee_key) fault_encode = `FC_EE_KEY;
    else if (f.ref_low[0]) fault_encode = `FC_LOW_X1;
    else if (f.ref_low[1]) fault_encode = `FC_LOW_X5;
    else if (f.ref_low[2]) fault_encode = `FC_LOW_X25;
    else if (f.ref_high[0]) fault_encode = `FC_HIGH_X1;
    else if (f.ref_high[1]) fault_encode = `FC_HIGH_X5;
    else if (f.ref_high[2]) fault_encode = `FC_HIGH_X25;
    else if (f.neutral_chan) fault_encode = `FC_NEUTRAL;
    else if (f.no_adc) fault_encode = `FC_NO_ADC;
    else fault_encode = 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // start counters and recorded history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_count <= '0;
      for (int i = 0; i < `HIST_DEPTH; i++) hist[i] <= '0;
    end else if (w_full) begin
      start_count <= '0;
      for (int i = 0; i < `HIST_DEPTH; i++) hist[i] <= '0;
    end else begin
      for (int s = 0; s < 3; s++) begin
        if (start_pulse[s] && start_count[s] != `COUNT_MAX) begin
          start_count[s] <= start_count[s] + 8'h01;
        end
      end
      if (rec_valid) begin
        for (int i = 1; i < `HIST_DEPTH; i++) hist[i] <= hist[i-1];
        hist[0] <= rec_in;
        if (rec_angle_low) hist[0].angle <= `ANGLE_INVALID;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond time base
  wire ms_tick = (ms_div == 32'(MS_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div <= 32'h0;
      time_ms <= 16'h0000;
    end else if (w_time) begin
      ms_div <= 32'h0;
      time_ms <= pwdata[15:0];
    end else begin
      ms_div <= ms_tick ? 32'h0 : ms_div + 32'h1;
      if (ms_tick) begin
        time_ms <= (time_ms == `TIME_MAX) ? 16'h0000 :
          time_ms + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events: mask, stamp, store, batch unload
  wire evt_enable = (evt_in.channel == 6'h0) ?
    stage_event_mask[evt_in.code[3:0]] & (evt_in.code < 8'h0C) :
    (evt_in.channel == 6'h1) ? output_event_mask_a[evt_in.code[2:0]] :
    (evt_in.channel == 6'h2) ? output_event_mask_b[evt_in.code[2:0]] :
    1'b1;
  wire push = evt_valid & evt_enable;
  wire pop = (state == st_pop) & ~evt_empty & (batch_cnt != `BATCH_LAST + 3'h1);
  wire overflow = push & evt_full;

  event_store store (
    .pclk(pclk),
    .presetn(presetn),
    .push(push),
    .push_data({time_ms, evt_in.channel, evt_in.code}),
    .pop(pop),
    .head(head),
    .empty(evt_empty),
    .full(evt_full)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      batch_cnt <= 3'h0;
      for (int i = 0; i < `BATCH; i++) batch[i] <= '0;
    end else begin
      case (state)
        st_idle: begin
          if (w_evt) begin
            batch_cnt <= 3'h0;
            state <= st_pop;
          end
        end
        st_pop: begin
          if (pop) begin
            batch[batch_cnt] <= head;
            batch_cnt <= batch_cnt + 3'h1;
          end else begin
            state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_auto <= 1'b0;
      st_overflow <= 1'b0;
    end else begin
      st_auto <= auto_reset_seen | (st_auto & ~w_stat);
      st_overflow <= overflow | (st_overflow & ~w_stat);
    end
  end
endmodule

// file: dv/relay_properties.sv
// concurrent checks on the ports of the relay interface
`timescale 1ns/1ps
`include "relay_params.svh"
module relay_properties #(
  parameter int MS_CYCLES = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ind_clear,
  input wire logic relay_release,
  input wire logic setting_bank_select,
  input wire logic self_supervision_out,
  input wire logic internal_fault_indicator,
  input wire logic format_req,
  input wire logic [7:0] station_address
);
  wire wr_done = psel && penable && pready && pwrite;
  wire bank_bit = pwdata[0];
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  property p_bank;
    wr_done && paddr == `OFS_BANK && !pslverr |=>
      setting_bank_select == $past(bank_bit);
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank select does not follow the write");
  property p_ind;
    wr_done && paddr == `OFS_IND_RST && pwdata == `W_ONE |=>
      ind_clear && relay_release;
  endproperty
  a_ind: assert property (p_ind)
    else $error("indicator reset gave no clear pulse");
  property p_full;
    wr_done && paddr == `OFS_FULL_RST && pwdata == `W_ONE |=>
      ind_clear && relay_release;
  endproperty
  a_full: assert property (p_full)
    else $error("full reset gave no clear pulse");
  property p_sup;
    wr_done && paddr == `OFS_SELF_SUP && pwdata == `W_ONE |=>
      self_supervision_out && internal_fault_indicator;
  endproperty
  a_sup: assert property (p_sup)
    else $error("self supervision not raised");
  property p_sup_hold;
    self_supervision_out |=> self_supervision_out;
  endproperty
  a_sup_hold: assert property (p_sup_hold)
    else $error("self supervision output dropped");
  property p_format;
    wr_done && paddr == `OFS_FORMAT && pwdata == `W_TWO && !pslverr |=>
      format_req ##1 !format_req;
  endproperty
  a_format: assert property (p_format)
    else $error("format request not a single pulse");
  property p_addr_range;
    station_address != 8'h00 && station_address != 8'hFF;
  endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("station address out of range");
  property p_addr_err;
    wr_done && paddr == `OFS_STATION &&
      (pwdata == 32'h0 || pwdata > `W_ADDR_MAX) |-> pslverr;
  endproperty
  a_addr_err: assert property (p_addr_err)
    else $error("bad station address accepted");
  property p_mask_err;
    wr_done && paddr == `OFS_MASK_STG && pwdata > `W_MASK_STG_MAX |-> pslverr;
  endproperty
  a_mask_err: assert property (p_mask_err)
    else $error("oversized stage mask accepted");
  property p_ro;
    wr_done && paddr == `OFS_STARTS |-> pslverr;
  endproperty
  a_ro: assert property (p_ro)
    else $error("start counters were writable");
endmodule
bind relay_parameter_event_interface relay_properties #(
  .MS_CYCLES(MS_CYCLES)
) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .ind_clear(ind_clear), .relay_release(relay_release),
  .setting_bank_select(setting_bank_select),
  .self_supervision_out(self_supervision_out),
  .internal_fault_indicator(internal_fault_indicator),
  .format_req(format_req), .station_address(station_address)
);

// file: dv/relay_comm_model.sv
// apb master standing in for the control data communicator
`timescale 1ns/1ps
module relay_comm_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // password opening and event unloading all go through here
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show garbage so a stale value cannot pass
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// file: dv/relay_parameter_event_interface_bench.sv
// self-checking bench for the relay parameter and event interface
`timescale 1ns/1ps
`include "relay_params.svh"
`define CHK(nm, e, g) \
  checks++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end
module relay_parameter_event_interface_bench
  import relay_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] start_pulse, sp;
  logic rec_valid, rec_angle_low, evt_valid, auto_reset_seen;
  rec_t rec_in, rv, ha;
  evt_in_t evt_in;
  fault_t fault_in;
  int miscompares, checks;
  int cnt [3];
  rec_t hist [$];
  logic [13:0] evq [$], last [$];
  logic [7:0] fcode [16] = '{8'hFD, 8'hFC, 8'hCB, 8'h8B, 8'h4B, 8'hC3,
    8'h83, 8'h43, 8'h38, 8'h37, 8'h36, 8'h34, 8'h33, 8'h32, 8'h1E, 8'h04};
  relay_parameter_event_interface #(.MS_CYCLES(10)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .start_pulse(start_pulse),
    .rec_valid(rec_valid), .rec_in(rec_in), .rec_angle_low(rec_angle_low),
    .evt_valid(evt_valid), .evt_in(evt_in), .fault_in(fault_in),
    .auto_reset_seen(auto_reset_seen), .ind_clear(), .relay_release(),
    .setting_bank_select(), .option_switch_group(),
    .self_supervision_out(), .internal_fault_indicator(), .format_req(),
    .station_address(), .link_rate()
  );
  relay_comm_model comm_u (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic e, input logic [31:0] x, input logic [31:0] m);
    logic [31:0] r;
    logic s;
    comm_u.xfer(w, a, d, r, s);
    `CHK("pslverr", e, s)
    if (!w && !e) begin
      `CHK("prdata", x, r & m)
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    acc(1'b1, a, d, e, 32'h0, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    acc(1'b0, a, 32'h0, 1'b0, x, 32'hFFFFFFFF);
  endtask
  task automatic push_ev(input int n);
    logic [7:0] c;
    repeat (n) begin
      c = 8'($urandom);
      @(posedge pclk);
      evt_valid <= 1'b1;
      evt_in <= {6'h05, c};
      if (evq.size() < 65) evq.push_back({6'h05, c});
    end
    @(posedge pclk);
    evt_valid <= 1'b0;
  endtask
  task automatic evread(input logic [31:0] cmd);
    if (cmd == 32'h1) begin
      last.delete();
      while (evq.size() > 0 && last.size() < 5) last.push_back(evq.pop_front());
    end
    wr(`OFS_EVT_CMD, cmd, 1'b0);
    rd(`OFS_EVT_CNT, 32'(last.size()));
    foreach (last[i]) acc(1'b0, `OFS_EVT_DATA + 8'(4 * i), 32'h0, 1'b0,
      32'(last[i]), 32'h3FFF);
  endtask
  task automatic pulse_auto();
    @(posedge pclk);
    auto_reset_seen <= 1'b1;
    @(posedge pclk);
    auto_reset_seen <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, start_pulse, rec_valid, rec_angle_low, evt_valid} = '0;
    {rec_in, evt_in, fault_in, auto_reset_seen} = '0;
    void'($urandom(30));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_STATION, 32'h1);
    rd(`OFS_MASK_STG, `W_MASK_STG_MAX);
    rd(`OFS_MASK_B, `W_MASK_OUT_MAX);
    wr(`OFS_MASK_STG, 32'h1000, 1'b1);
    wr(`OFS_MASK_A, 32'h100, 1'b1);
    wr(`OFS_STARTS, 32'h0, 1'b1);
    acc(1'b0, 8'hF0, 32'h0, 1'b1, 32'h0, 32'h0);
    repeat (300) begin
      @(posedge pclk);
      sp = {2'($urandom), 1'b1};
      start_pulse <= sp;
      for (int k = 0; k < 3; k++) if (sp[k] && cnt[k] < 255) cnt[k]++;
    end
    @(posedge pclk);
    start_pulse <= 3'h0;
    rd(`OFS_STARTS, {8'h0, 8'(cnt[2]), 8'(cnt[1]), 8'(cnt[0])});
    for (int j = 0; j < 6; j++) begin
      rv = rec_t'({$urandom, $urandom});
      rv.angle = 11'($urandom_range(360)) - 11'd180;
      @(posedge pclk);
      rec_valid <= 1'b1;
      rec_in <= rv;
      rec_angle_low <= (j == 3);
      if (j == 3) rv.angle = `ANGLE_INVALID;
      hist.push_front(rv);
    end
    @(posedge pclk);
    rec_valid <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_HIST_SEL, 32'(i), 1'b0);
      ha = hist[i];
      rd(`OFS_HIST_A, {{5{ha.angle[10]}}, ha.angle, ha.current, 1'b0,
        ha.voltage});
      rd(`OFS_HIST_B, {11'h0, ha.duration});
    end
    wr(`OFS_FULL_RST, 32'h1, 1'b0);
    rd(`OFS_STARTS, 32'h0);
    wr(`OFS_HIST_SEL, 32'h0, 1'b0);
    rd(`OFS_HIST_A, 32'h0);
    wr(`OFS_IND_RST, 32'h1, 1'b0);
    for (int b = 1; b >= 0; b--) begin
      wr(`OFS_BANK, 32'(b), 1'b0);
      rd(`OFS_BANK, 32'(b));
    end
    wr(`OFS_BANK, 32'h2, 1'b1);
    wr(`OFS_STATION, 32'h0, 1'b1);
    wr(`OFS_STATION, 32'hFF, 1'b1);
    wr(`OFS_STATION, 32'hFE, 1'b0);
    rd(`OFS_STATION, 32'hFE);
    // remote setting locked until the password opens it
    wr(`OFS_SGX, 32'h1, 1'b1);
    wr(`OFS_PW_CHG, 32'h7, 1'b1);
    wr(`OFS_FORMAT, 32'h2, 1'b1);
    wr(`OFS_PW_OPEN, 32'h5, 1'b1);
    wr(`OFS_PW_OPEN, 32'h1, 1'b0);
    wr(`OFS_SGX, 32'h3F, 1'b0);
    rd(`OFS_SGX, 32'h3F);
    wr(`OFS_PW_CHG, 32'h3E7, 1'b0);
    wr(`OFS_FORMAT, 32'h2, 1'b0);
    wr(`OFS_PW_CHG, 32'h0, 1'b0);
    wr(`OFS_SGX, 32'h1, 1'b1);
    wr(`OFS_PW_OPEN, 32'h1, 1'b1);
    wr(`OFS_PW_OPEN, 32'h3E7, 1'b0);
    push_ev(7);
    evread(32'h1);
    evread(32'h2);
    evread(32'h2);
    evread(32'h1);
    evread(32'h1);
    push_ev(66);
    rd(`OFS_STATUS, 32'h2);
    pulse_auto();
    rd(`OFS_STATUS, 32'h3);
    wr(`OFS_STATUS, 32'h1, 1'b1);
    wr(`OFS_STATUS, 32'h0, 1'b0);
    rd(`OFS_STATUS, 32'h0);
    pulse_auto();
    rd(`OFS_STATUS, 32'h1);
    repeat (14) evread(32'h1);
    for (int i = 0; i < 16; i++) begin
      fault_in <= fault_t'(16'h1 << i);
      rd(`OFS_FAULT, 32'(fcode[i]));
    end
    fault_in <= fault_t'(16'h1800);
    rd(`OFS_FAULT, 32'h35);
    fault_in <= fault_t'(16'h0);
    rd(`OFS_FAULT, 32'h0);
    wr(`OFS_TIME, `W_TIME_MAX, 1'b0);
    repeat (10) @(posedge pclk);
    rd(`OFS_TIME, 32'h0);
    wr(`OFS_SELF_SUP, 32'h1, 1'b0);
    repeat (4) @(posedge pclk);
    give_verdict();
  end
  // far above the fewer than two thousand cycles needed
  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end
endmodule
